// ==== src/twm_map.svh ====
/*
 * Register offsets, field positions, reset values and status codes of the
 * two-wire master receiver. Assumes inclusion by bare name from src/.
 */
`ifndef TWM_MAP_SVH
`define TWM_MAP_SVH

// Byte offsets on the APB
`define TWM_CTRL_OFS 8'h00
`define TWM_STAT_OFS 8'h04
`define TWM_DATA_OFS 8'h08
`define TWM_RATE_OFS 8'h0C

// serial_control field positions
`define TWM_CTRL_DONE 7
`define TWM_CTRL_ACK 6
`define TWM_CTRL_STA 5
`define TWM_CTRL_STO 4
`define TWM_CTRL_WCOL 3
`define TWM_CTRL_EN 2
`define TWM_CTRL_IE 0

// Reset values
`define TWM_DATA_RST 8'hFF
`define TWM_RATE_RST 8'h18
`define TWM_PRESC_RST 2'h0

// Status codes, prescaler bits zero
`define TWM_ST_START 8'h08
`define TWM_ST_RSTART 8'h10
`define TWM_ST_WA_ACK 8'h18
`define TWM_ST_WA_NACK 8'h20
`define TWM_ST_TD_ACK 8'h28
`define TWM_ST_TD_NACK 8'h30
`define TWM_ST_LOST 8'h38
`define TWM_ST_RA_ACK 8'h40
`define TWM_ST_RA_NACK 8'h48
`define TWM_ST_RD_ACK 8'h50
`define TWM_ST_RD_NACK 8'h58
`define TWM_ST_IDLE 8'hF8

`endif

// ==== src/twm_pkg.sv ====
/*
 * Types of the two-wire master receiver.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package twm_pkg;

   typedef enum logic [2:0] {
      S_IDLE,
      S_WFREE,
      S_START,
      S_XFER,
      S_WAIT,
      S_STOP
   } state_type;

   typedef struct packed {
      logic [7:0] data;
      logic nack;
   } rx_entry_type;

endpackage : twm_pkg

// ==== src/twm_sync.sv ====
/*
 * Two-flop synchroniser for a group of pins.
 * Assumes inputs asynchronous to clock; output read by any logic.
 */
module twm_sync #(
   parameter int WIDTH = 2
) (
   input wire logic clock, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire logic ce, // Clock enable
   input wire logic [WIDTH-1:0] din, // Asynchronous inputs
   output logic [WIDTH-1:0] dout // Synchronised levels
);

   logic [WIDTH-1:0] meta_ff;
   logic [WIDTH-1:0] sync_ff;

   always_ff @(posedge clock) begin
      if (srst) begin
         meta_ff <= '1;
         sync_ff <= '1;
      end else if (ce) begin
         meta_ff <= din;
         sync_ff <= meta_ff;
      end
   end

   assign dout = sync_ff;

endmodule : twm_sync

// ==== src/twm_buf.sv ====
/*
 * Two-entry buffer with valid and ready on both sides.
 * Assumes one clock; in and out may act in the same cycle.
 */
module twm_buf #(
   parameter int WIDTH = 9
) (
   input wire logic clock, // System clock
   input wire logic srst, // Synchronous reset, high
   input wire logic ce, // Clock enable
   input wire logic inValid, // Word offered
   output logic inReady, // Room for a word
   input wire logic [WIDTH-1:0] inData, // Word in
   output logic outValid, // Word available
   input wire logic outReady, // Drain takes word
   output logic [WIDTH-1:0] outData // Oldest word
);

   logic [WIDTH-1:0] mem [2];
   logic wrPtr_ff;
   logic rdPtr_ff;
   logic [1:0] count_ff;
   logic push;
   logic pop;

   assign inReady = (count_ff != 2'h2);
   assign outValid = (count_ff != 2'h0);
   assign outData = mem[rdPtr_ff];
   assign push = inValid && inReady;
   assign pop = outValid && outReady;

   always_ff @(posedge clock) begin
      if (ce && push) begin
         mem[wrPtr_ff] <= inData;
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         wrPtr_ff <= 1'b0;
         rdPtr_ff <= 1'b0;
         count_ff <= 2'h0;
      end else if (ce) begin
         if (push) begin
            wrPtr_ff <= !wrPtr_ff;
         end
         if (pop) begin
            rdPtr_ff <= !rdPtr_ff;
         end
         if (push && !pop) begin
            count_ff <= count_ff + 2'h1;
         end else if (pop && !push) begin
            count_ff <= count_ff - 2'h1;
         end
      end
   end

endmodule : twm_buf

// ==== src/twm_master.sv ====
/*
 * Two-wire bus master (receiver with address and byte transmit) behind an
 * APB slave. Assumes open-drain SCL and SDA resolved outside; pins are
 * asynchronous to clock and pass a two-flop synchroniser.
 */
`include "twm_map.svh"
module twm_master (
   input wire logic clock, // System clock, 25 MHz
   input wire logic srst, // Synchronous reset, high
   input wire logic ce, // Clock enable, freezes all state
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] pwdata, // APB write data
   input wire logic [3:0] pstrb, // APB byte strobes
   output logic [31:0] prdata, // APB read data
   output logic pready, // APB ready
   output logic pslverr, // APB error, unmapped address
   input wire logic sclIn, // Serial clock level
   output logic sclOut, // Serial clock drive value
   output logic sclOe, // Serial clock pulled low
   input wire logic sdaIn, // Serial data level
   output logic sdaOut, // Serial data drive value
   output logic sdaOe // Serial data pulled low
);

   twm_pkg::state_type state_ff;
   logic [1:0] phase_ff;
   logic [7:0] qCnt_ff;
   logic [3:0] bitCnt_ff;
   logic [7:0] shift_ff;
   logic byteRx_ff, addrPhase_ff, addrRw_ff, ackSend_ff, ackRx_ff;
   logic owner_ff, repStart_ff, busy_ff;
   logic sclPrev_ff, sdaPrev_ff;
   logic sclOe_ff, sdaOe_ff;
   logic [7:0] status_ff;
   logic doneSet_ff;
   logic stepDone_ff, ackEn_ff, sta_ff, sto_ff, wcol_ff, en_ff, ie_ff;
   logic [1:0] presc_ff;
   logic [7:0] data_ff, rate_ff;
   logic goP_ff;
   logic sclS, sdaS, sclWait, tick, stopSent, lostNow;
   logic access, wrLane, ctrlWr, dataWr;
   logic mapped;
   logic [7:0] rdByte;
   logic bufInValid, bufInReady, bufOutValid, bufOutReady;
   twm_pkg::rx_entry_type bufIn, bufOut;

   twm_sync #(.WIDTH(2)) u_sync (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .din({sclIn, sdaIn}),
      .dout({sclS, sdaS})
   );

   // Received bytes wait here while software still holds the previous step
   twm_buf #(.WIDTH($bits(twm_pkg::rx_entry_type))) u_buf (
      .clock(clock),
      .srst(srst),
      .ce(ce),
      .inValid(bufInValid),
      .inReady(bufInReady),
      .inData(bufIn),
      .outValid(bufOutValid),
      .outReady(bufOutReady),
      .outData(bufOut)
   );

   // Quarter-bit timing; the phase that needs SCL high waits while it is held low
   assign sclWait = (state_ff == twm_pkg::S_XFER) ? (phase_ff == 2'h1) : (phase_ff == 2'h2);
   assign tick = (qCnt_ff == rate_ff) && !(sclWait && !sclS);
   assign stopSent = (state_ff == twm_pkg::S_STOP) && (phase_ff == 2'h3) && tick;
   assign lostNow = (state_ff == twm_pkg::S_XFER) && (phase_ff == 2'h1) && tick
      && !sdaOe_ff && !sdaS
      && ((bitCnt_ff != 4'h8 && !byteRx_ff) || (bitCnt_ff == 4'h8 && byteRx_ff));
   assign bufIn = '{data: shift_ff, nack: !ackSend_ff};
   assign bufInValid = (state_ff == twm_pkg::S_XFER) && (phase_ff == 2'h3) && tick
      && (bitCnt_ff == 4'h8) && byteRx_ff && !addrPhase_ff;
   assign bufOutReady = !stepDone_ff && !doneSet_ff;

   always_ff @(posedge clock) begin
      if (srst) begin
         qCnt_ff <= 8'h00;
      end else if (ce) begin
         if (state_ff == twm_pkg::S_IDLE || state_ff == twm_pkg::S_WAIT
               || state_ff == twm_pkg::S_WFREE || tick) begin
            qCnt_ff <= 8'h00;
         end else if (qCnt_ff != rate_ff) begin
            qCnt_ff <= qCnt_ff + 8'h01;
         end
      end
   end

   // Bus monitor: busy from any START until a STOP
   always_ff @(posedge clock) begin
      if (srst) begin
         sclPrev_ff <= 1'b1;
         sdaPrev_ff <= 1'b1;
         busy_ff <= 1'b0;
      end else if (ce) begin
         sclPrev_ff <= sclS;
         sdaPrev_ff <= sdaS;
         if (sclS && sclPrev_ff && sdaPrev_ff && !sdaS) begin
            busy_ff <= 1'b1;
         end else if (sclS && sclPrev_ff && !sdaPrev_ff && sdaS) begin
            busy_ff <= 1'b0;
         end
      end
   end

   // Bus engine
   always_ff @(posedge clock) begin
      if (srst || (ce && !en_ff)) begin
         state_ff <= twm_pkg::S_IDLE;
         phase_ff <= 2'h0;
         bitCnt_ff <= 4'h0;
         shift_ff <= 8'h00;
         byteRx_ff <= 1'b0;
         addrPhase_ff <= 1'b0;
         addrRw_ff <= 1'b0;
         ackSend_ff <= 1'b0;
         ackRx_ff <= 1'b0;
         owner_ff <= 1'b0;
         repStart_ff <= 1'b0;
         sclOe_ff <= 1'b0;
         sdaOe_ff <= 1'b0;
         status_ff <= `TWM_ST_IDLE;
         doneSet_ff <= 1'b0;
      end else if (ce) begin
         doneSet_ff <= 1'b0;
         if (bufOutValid && bufOutReady) begin
            status_ff <= bufOut.nack ? `TWM_ST_RD_NACK : `TWM_ST_RD_ACK;
            doneSet_ff <= 1'b1;
         end
         unique case (state_ff)
            twm_pkg::S_IDLE: begin
               phase_ff <= 2'h0;
               if (goP_ff && sta_ff) begin
                  state_ff <= twm_pkg::S_WFREE;
               end
            end
            twm_pkg::S_WFREE: begin
               if (!busy_ff) begin
                  state_ff <= twm_pkg::S_START;
                  repStart_ff <= 1'b0;
                  phase_ff <= 2'h0;
               end
            end
            twm_pkg::S_START: begin
               if (tick) begin
                  phase_ff <= phase_ff + 2'h1;
                  unique case (phase_ff)
                     2'h0: sdaOe_ff <= 1'b0;
                     2'h1: sclOe_ff <= 1'b0;
                     2'h2: sdaOe_ff <= 1'b1;
                     2'h3: begin
                        sclOe_ff <= 1'b1;
                        owner_ff <= 1'b1;
                        status_ff <= repStart_ff ? `TWM_ST_RSTART : `TWM_ST_START;
                        doneSet_ff <= 1'b1;
                        state_ff <= twm_pkg::S_WAIT;
                     end
                  endcase
               end
            end
            twm_pkg::S_STOP: begin
               if (tick) begin
                  phase_ff <= phase_ff + 2'h1;
                  unique case (phase_ff)
                     2'h0: sdaOe_ff <= 1'b1;
                     2'h1: sclOe_ff <= 1'b0;
                     2'h2: sdaOe_ff <= 1'b0;
                     2'h3: begin
                        owner_ff <= 1'b0;
                        status_ff <= `TWM_ST_IDLE;
                        state_ff <= sta_ff ? twm_pkg::S_WFREE : twm_pkg::S_IDLE;
                     end
                  endcase
               end
            end
            twm_pkg::S_XFER: begin
               if (lostNow) begin
                  sclOe_ff <= 1'b0;
                  sdaOe_ff <= 1'b0;
                  owner_ff <= 1'b0;
                  status_ff <= `TWM_ST_LOST;
                  doneSet_ff <= 1'b1;
                  state_ff <= twm_pkg::S_WAIT;
               end else if (tick && !(bufInValid && !bufInReady)) begin
                  phase_ff <= phase_ff + 2'h1;
                  unique case (phase_ff)
                     2'h0: sclOe_ff <= 1'b0;
                     2'h1: begin
                        if (bitCnt_ff == 4'h8) begin
                           ackRx_ff <= !sdaS;
                        end else begin
                           shift_ff <= {shift_ff[6:0], sdaS};
                        end
                     end
                     2'h2: sclOe_ff <= 1'b1;
                     2'h3: begin
                        if (bitCnt_ff == 4'h7) begin
                           sdaOe_ff <= byteRx_ff && ackEn_ff;
                           ackSend_ff <= ackEn_ff;
                        end else if (bitCnt_ff != 4'h8) begin
                           sdaOe_ff <= !byteRx_ff && !shift_ff[7];
                        end else begin
                           sdaOe_ff <= 1'b0;
                        end
                        bitCnt_ff <= bitCnt_ff + 4'h1;
                        if (bitCnt_ff == 4'h8) begin
                           state_ff <= twm_pkg::S_WAIT;
                           if (addrPhase_ff && addrRw_ff) begin
                              status_ff <= ackRx_ff ? `TWM_ST_RA_ACK : `TWM_ST_RA_NACK;
                              doneSet_ff <= 1'b1;
                           end else if (addrPhase_ff) begin
                              status_ff <= ackRx_ff ? `TWM_ST_WA_ACK : `TWM_ST_WA_NACK;
                              doneSet_ff <= 1'b1;
                           end else if (!byteRx_ff) begin
                              status_ff <= ackRx_ff ? `TWM_ST_TD_ACK : `TWM_ST_TD_NACK;
                              doneSet_ff <= 1'b1;
                           end
                        end
                     end
                  endcase
               end
            end
            twm_pkg::S_WAIT: begin
               phase_ff <= 2'h0;
               bitCnt_ff <= 4'h0;
               if (goP_ff) begin
                  if (!owner_ff) begin
                     state_ff <= sta_ff ? twm_pkg::S_WFREE : twm_pkg::S_IDLE;
                     status_ff <= `TWM_ST_IDLE;
                  end else if (sto_ff) begin
                     state_ff <= twm_pkg::S_STOP;
                  end else if (sta_ff) begin
                     state_ff <= twm_pkg::S_START;
                     repStart_ff <= 1'b1;
                  end else if (status_ff == `TWM_ST_START || status_ff == `TWM_ST_RSTART) begin
                     shift_ff <= data_ff;
                     addrPhase_ff <= 1'b1;
                     addrRw_ff <= data_ff[0];
                     byteRx_ff <= 1'b0;
                     sdaOe_ff <= !data_ff[7];
                     state_ff <= twm_pkg::S_XFER;
                  end else if (status_ff == `TWM_ST_RA_ACK || status_ff == `TWM_ST_RD_ACK) begin
                     addrPhase_ff <= 1'b0;
                     byteRx_ff <= 1'b1;
                     sdaOe_ff <= 1'b0;
                     state_ff <= twm_pkg::S_XFER;
                  end else if (status_ff == `TWM_ST_WA_ACK || status_ff == `TWM_ST_WA_NACK
                        || status_ff == `TWM_ST_TD_ACK || status_ff == `TWM_ST_TD_NACK) begin
                     shift_ff <= data_ff;
                     addrPhase_ff <= 1'b0;
                     byteRx_ff <= 1'b0;
                     sdaOe_ff <= !data_ff[7];
                     state_ff <= twm_pkg::S_XFER;
                  end
               end
            end
            default: state_ff <= twm_pkg::S_IDLE;
         endcase
      end
   end

   // APB decode; one wait state, answer registered
   assign access = psel && penable && pready;
   assign wrLane = access && pwrite && pstrb[0] && mapped;
   assign ctrlWr = wrLane && (paddr == `TWM_CTRL_OFS);
   assign dataWr = wrLane && (paddr == `TWM_DATA_OFS);
   assign mapped = (paddr == `TWM_CTRL_OFS) || (paddr == `TWM_STAT_OFS)
      || (paddr == `TWM_DATA_OFS) || (paddr == `TWM_RATE_OFS);

   always_comb begin
      rdByte = 8'h00;
      unique case (paddr)
         `TWM_CTRL_OFS: rdByte = {stepDone_ff, ackEn_ff, sta_ff, sto_ff,
            wcol_ff, en_ff, 1'b0, ie_ff};
         `TWM_STAT_OFS: rdByte = {status_ff[7:3], 1'b0, presc_ff};
         `TWM_DATA_OFS: rdByte = data_ff;
         `TWM_RATE_OFS: rdByte = rate_ff;
         default: rdByte = 8'h00;
      endcase
   end

   // Answer flops drive the ports; a write commits at the edge that samples pready
   always_ff @(posedge clock) begin
      if (srst) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
      end else if (ce) begin
         pready <= psel && penable && !pready;
         pslverr <= psel && penable && !pready && !mapped;
         prdata <= {24'h00_0000, rdByte};
      end
   end

   // serial_control
   always_ff @(posedge clock) begin
      if (srst) begin
         stepDone_ff <= 1'b0;
         ackEn_ff <= 1'b0;
         sta_ff <= 1'b0;
         sto_ff <= 1'b0;
         en_ff <= 1'b0;
         ie_ff <= 1'b0;
         goP_ff <= 1'b0;
      end else if (ce) begin
         goP_ff <= ctrlWr && pwdata[`TWM_CTRL_DONE] && pwdata[`TWM_CTRL_EN]
            && !doneSet_ff;
         if (doneSet_ff) begin
            stepDone_ff <= 1'b1;
         end else if (ctrlWr && pwdata[`TWM_CTRL_DONE]) begin
            stepDone_ff <= 1'b0;
         end
         if (ctrlWr) begin
            ackEn_ff <= pwdata[`TWM_CTRL_ACK];
            sta_ff <= pwdata[`TWM_CTRL_STA];
            sto_ff <= pwdata[`TWM_CTRL_STO];
            en_ff <= pwdata[`TWM_CTRL_EN];
            ie_ff <= pwdata[`TWM_CTRL_IE];
         end else if (stopSent) begin
            sto_ff <= 1'b0;
         end
      end
   end

   // serial_data, collision flag, serial_status prescaler, bit rate
   always_ff @(posedge clock) begin
      if (srst) begin
         data_ff <= `TWM_DATA_RST;
         wcol_ff <= 1'b0;
         presc_ff <= `TWM_PRESC_RST;
         rate_ff <= `TWM_RATE_RST;
      end else if (ce) begin
         if (bufOutValid && bufOutReady) begin
            data_ff <= bufOut.data;
         end else if (dataWr && stepDone_ff) begin
            data_ff <= pwdata[7:0];
         end
         if (dataWr) begin
            wcol_ff <= !stepDone_ff;
         end
         if (wrLane && paddr == `TWM_STAT_OFS) begin
            presc_ff <= pwdata[1:0];
         end
         if (wrLane && paddr == `TWM_RATE_OFS) begin
            rate_ff <= (pwdata[7:0] == 8'h00) ? 8'h01 : pwdata[7:0];
         end
      end
   end

   always_ff @(posedge clock) begin
      if (srst) begin
         sclOut <= 1'b0;
         sdaOut <= 1'b0;
         sclOe <= 1'b0;
         sdaOe <= 1'b0;
      end else if (ce) begin
         sclOe <= sclOe_ff;
         sdaOe <= sdaOe_ff;
      end
   end

endmodule : twm_master

// ==== sim/twm_slave_model.sv ====
/*
 * Behavioural slave transmitter on the two-wire bus.
 * Assumes open-drain lines resolved by the bench with pull-ups.
 */
module twm_slave_model #(
   parameter logic [6:0] ADDR = 7'h2A, // Own address
   parameter logic [7:0] DATA0 = 8'h96, // First byte sent, then counts up
   parameter int SLOW = 0 // Clock stretch after own address, ns
) (
   input wire logic scl, // Serial clock level
   input wire logic sda, // Serial data level
   output logic sclPull, // Holds clock low
   output logic sdaPull // Holds data low
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] sh;
   logic [7:0] tx;
   logic ack;
   initial begin
      sclPull = 1'h0;
      sdaPull = 1'h0;
      forever begin
         @(negedge sda iff scl === 1'h1);
         repeat (8) begin
            @(posedge scl);
            sh = {sh[6:0], sda};
         end
         @(negedge scl);
         if (sh === {ADDR, 1'h1}) begin
            sdaPull = 1'h1;
            sclPull = SLOW > 0;
            #(SLOW);
            sclPull = 1'h0;
            @(negedge scl);
            tx = DATA0;
            ack = 1'h1;
            while (ack) begin
               for (int i = 7; i >= 0; i--) begin
                  sdaPull = !tx[i];
                  @(negedge scl);
               end
               sdaPull = 1'h0;
               @(posedge scl);
               ack = !sda;
               @(negedge scl);
               tx = tx + 8'h01;
            end
         end
      end
   end
endmodule : twm_slave_model

// ==== sim/twm_master_assertions.sv ====
/*
 * Port checker for the two-wire master.
 * Assumes binding to twm_master; one clock domain.
 */
`include "twm_map.svh"
module twm_master_assertions (
   input wire logic clock, // System clock
   input wire logic srst, // Synchronous reset
   input wire logic [7:0] paddr, // APB address
   input wire logic psel, // APB select
   input wire logic penable, // APB enable
   input wire logic pwrite, // APB direction
   input wire logic [31:0] prdata, // APB read data
   input wire logic pready, // APB ready
   input wire logic pslverr, // APB error
   input wire logic sclIn, // Clock line level
   input wire logic sclOut, // Clock drive value
   input wire logic sclOe, // Clock pulled low
   input wire logic sdaOut, // Data drive value
   input wire logic sdaOe // Data pulled low
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (srst);
   logic mapped;
   assign mapped = paddr inside {`TWM_CTRL_OFS, `TWM_STAT_OFS, `TWM_DATA_OFS, `TWM_RATE_OFS};
   a_ready_wait: assert property (psel && !penable |-> ##[1:4] pready)
      else $error("pready late after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_decode: assert property (pready |-> pslverr == !mapped)
      else $error("pslverr does not follow address decode");
   a_rdata_upper: assert property (pready |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits not zero");
   a_unmapped_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
      else $error("unmapped read not zero");
   a_start_free: assert property ($rose(sdaOe) && !sclOe |-> sclIn)
      else $error("start made while clock line low");
   a_start_clock: assert property ($rose(sdaOe) && !sclOe |-> ##[1:600] sclOe)
      else $error("no clock after start");
   a_drive_zero: assert property (!sclOut && !sdaOut)
      else $error("open drain value not zero");
   a_reset_lines: assert property ($fell(srst) |-> !sclOe && !sdaOe)
      else $error("lines not released after reset");
   c_unmapped: cover property (pready && pslverr);
   c_start: cover property ($rose(sdaOe) && !sclOe);
   c_write: cover property (pready && pwrite && !pslverr);
endmodule : twm_master_assertions
bind twm_master twm_master_assertions u_twm_master_assertions (.clock, .srst, .paddr, .psel,
   .penable, .pwrite, .prdata, .pready, .pslverr, .sclIn, .sclOut, .sclOe, .sdaOut, .sdaOe);

// ==== sim/tb_twm_master.sv ====
/*
 * Testbench of the two-wire master receiver: APB software steps.
 * Assumes the slave model and the bound port checker.
 */
`include "twm_map.svh"
module tb_twm_master;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] SLV = 7'h2A;
   localparam logic [6:0] OTHER = 7'h11;
   localparam logic [7:0] DATA0 = 8'h96;
   logic clock = 1'h0;
   logic srst = 1'h1;
   logic psel = 1'h0;
   logic penable = 1'h0;
   logic pwrite = 1'h0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic [31:0] rd;
   logic pready, pslverr, rdErr, sclOe, sdaOe, sclPull, sdaPull, scl, sda;
   logic sdaJam = 1'h0;
   int errCount = 0;
   int numChecks = 0;
   int cycles = 0;
   always #20 clock = ~clock;
   assign scl = !(sclOe || sclPull);
   // Second driver on SDA stands in for a competing master
   assign sda = !(sdaOe || sdaPull || sdaJam);
   twm_master u_twm_master (.clock(clock), .srst(srst), .ce(1'h1), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sclIn(scl), .sclOut(), .sclOe(sclOe),
      .sdaIn(sda), .sdaOut(), .sdaOe(sdaOe));
   twm_slave_model #(.ADDR(SLV), .DATA0(DATA0), .SLOW(600)) u_twm_slave_model (.scl(scl),
      .sda(sda), .sclPull(sclPull), .sdaPull(sdaPull));
   task automatic conclude();
      $display("checks %0d errors %0d", numChecks, errCount);
      if (errCount == 0 && numChecks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : conclude
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      numChecks++;
      if (got !== exp) begin
         errCount++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge clock);
      psel <= 1'h1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'h1;
      do begin
         @(posedge clock);
      end while (pready !== 1'h1);
      rd = prdata;
      rdErr = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
   endtask : apb
   // Command write, wait for the flag, compare the masked status code
   task automatic step(input logic [7:0] c, input logic [7:0] st);
      apb(1'h1, `TWM_CTRL_OFS, {24'h0, c});
      do apb(1'h0, `TWM_CTRL_OFS, 32'h0); while (rd[7] !== 1'h1);
      apb(1'h0, `TWM_STAT_OFS, 32'h0);
      chk("status", rd & 32'hF8, {24'h0, st});
   endtask : step
   always @(posedge clock) begin
      cycles++;
      if (cycles == 20000) begin
         errCount++;
         conclude();
      end
   end
   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'h0;
      apb(1'h0, `TWM_STAT_OFS, 32'h0);
      chk("status reset", rd, 32'hF8);
      apb(1'h0, `TWM_DATA_OFS, 32'h0);
      chk("data reset", rd, 32'hFF);
      apb(1'h0, `TWM_RATE_OFS, 32'h0);
      chk("rate reset", rd, 32'h18);
      apb(1'h0, `TWM_CTRL_OFS, 32'h0);
      chk("control reset", rd, 32'h0);
      apb(1'h1, 8'h10, 32'h55);
      chk("unmapped error", rdErr, 32'h1);
      apb(1'h0, 8'h10, 32'h0);
      chk("unmapped read", rd, 32'h0);
      // Prescaler bits set, so every status code must be masked
      apb(1'h1, `TWM_STAT_OFS, 32'h3);
      apb(1'h1, `TWM_RATE_OFS, 32'h1);
      step(8'hA4, `TWM_ST_START);
      apb(1'h1, `TWM_CTRL_OFS, 32'h04);
      apb(1'h0, `TWM_CTRL_OFS, 32'h0);
      chk("flag held", rd[7], 32'h1);
      apb(1'h1, `TWM_DATA_OFS, {24'h0, SLV, 1'h1});
      step(8'hC4, `TWM_ST_RA_ACK);
      step(8'hC4, `TWM_ST_RD_ACK);
      apb(1'h0, `TWM_DATA_OFS, 32'h0);
      chk("byte 0", rd, {24'h0, DATA0});
      step(8'h84, `TWM_ST_RD_NACK);
      apb(1'h0, `TWM_DATA_OFS, 32'h0);
      chk("byte 1", rd, {24'h0, DATA0 + 8'h01});
      step(8'hA4, `TWM_ST_RSTART);
      apb(1'h1, `TWM_DATA_OFS, {24'h0, SLV, 1'h0});
      step(8'h84, `TWM_ST_WA_NACK);
      step(8'hA4, `TWM_ST_RSTART);
      apb(1'h1, `TWM_DATA_OFS, {24'h0, OTHER, 1'h1});
      step(8'h84, `TWM_ST_RA_NACK);
      step(8'hA4, `TWM_ST_RSTART);
      apb(1'h1, `TWM_DATA_OFS, {24'h0, OTHER, 1'h1});
      step(8'h84, `TWM_ST_RA_NACK);
      step(8'hB4, `TWM_ST_START);
      apb(1'h1, `TWM_DATA_OFS, {24'h0, OTHER, 1'h1});
      step(8'h84, `TWM_ST_RA_NACK);
      apb(1'h1, `TWM_CTRL_OFS, 32'h94);
      do apb(1'h0, `TWM_STAT_OFS, 32'h0); while ((rd & 32'hF8) !== 32'hF8);
      apb(1'h0, `TWM_CTRL_OFS, 32'h0);
      chk("stop request", rd[4], 32'h0);
      chk("clock idle", scl, 32'h1);
      chk("data idle", sda, 32'h1);
      // SDA held low under a released address bit loses arbitration
      step(8'hA4, `TWM_ST_START);
      sdaJam <= 1'h1;
      apb(1'h1, `TWM_DATA_OFS, {24'h0, OTHER, 1'h1});
      step(8'h84, `TWM_ST_LOST);
      chk("lost clock free", scl, 32'h1);
      sdaJam <= 1'h0;
      step(8'hA4, `TWM_ST_START);
      conclude();
   end
endmodule : tb_twm_master
